/* flash_config_status_registers.sv */
// serial-command configuration and status registers of a stacked flash
// Summary of operation
// - 3-byte mode: segment gives top bits
// - 3-byte program/erase confined to chosen segment
// - 3-byte reads wrap within the selected die
// - read crossing segment leaves register alone
// - code 000 lowest up to 111
// - strap sets start segment, command rewrites
// - 4-byte mode ignores segment register
// - config bit 7 low selects quad
// - config bit 6 low selects dual
// - both low is quad, after write
// - config bit 4 enables hold/reset
// - config bit 3 low enables accelerator
// - config readable, writable, applied on completion
// - flag bit 7 is not busy
// - bits 6/2 show erase/program suspend
// - bit 5 latches erase failure
// - bit 4 latches program failure
// - bit 3 latches bad accelerator voltage
// - bit 1 latches protection violation
// - bit 0 shows address mode
// - errors sticky until clear command
// - flags returned by read flags command
// - write segment opcode c5h
// - read segment opcode c8h
// - read flags 70h, repeats while clocked
// - clear flags 50h, no data
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_params.svh"

module flash_config_status_registers
  import flash_regs_pkg::*;
(
  // system
  input  wire logic                      clk_sys_in,
  input  wire logic                      reset_n_in,
  // serial link
  input  wire logic                      spi_sclk_in,
  input  wire logic                      spi_cs_n_in,
  input  wire logic                      spi_mosi_in,
  output logic                           spi_miso_out,
  output logic                           spi_miso_oe_out,
  // nonvolatile strap
  input  wire logic                      nv_segment_low_in,
  // controller status levels
  input  wire logic                      write_in_progress_in,
  input  wire logic                      erase_suspend_in,
  input  wire logic                      program_suspend_in,
  input  wire logic                      four_byte_mode_in,
  // controller error events
  input  wire logic                      erase_fail_in,
  input  wire logic                      program_fail_in,
  input  wire logic                      zero_to_one_in,
  input  wire logic                      vpp_invalid_in,
  input  wire logic                      protect_hit_in,
  // array addressing
  input  wire logic [31:0]               core_addr_in,
  input  wire logic                      read_start_in,
  input  wire logic                      read_advance_in,
  input  wire logic                      pe_start_in,
  output logic      [`ARRAY_ADDR_W-1:0]  array_addr_out,
  // configuration and status outputs
  output protocol_e                      protocol_out,
  output logic                           hold_reset_en_out,
  output logic                           vpp_accel_en_out,
  output logic      [2:0]                drive_strength_out,
  output logic      [2:0]                segment_out,
  output logic      [7:0]                flag_status_out
);

  logic [2:0]  sclk_sync_reg;
  logic [2:0]  cs_sync_reg;
  logic [1:0]  mosi_sync_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  link_state_e state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [2:0]  out_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  opcode_reg;
  logic [7:0]  wr_data_reg;
  logic        wr_full_reg;
  logic        clear_ok_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  cmd_byte;
  logic        seg_wr_pulse;
  logic        cfg_wr_pulse;
  logic        clr_pulse;
  logic        strap_done_reg;
  logic [7:0]  cfg_reg;

  // value returned by a register read command
  function automatic logic [7:0] read_value(
    input logic [7:0] op,
    input logic [2:0] seg,
    input logic [7:0] cfg,
    input logic [7:0] flg
  );
    case (op)
      `OP_READ_SEGMENT: read_value = {5'h00, seg};
      `OP_READ_CONFIG:  read_value = cfg;
      `OP_READ_FLAGS:   read_value = flg;
      default:          read_value = 8'h00;
    endcase
  endfunction : read_value

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      mosi_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_in};
      cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_in};
    end
  end

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign cmd_byte  = {shift_reg[6:0], mosi_sync_reg[1]};

  // command framing state machine
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      opcode_reg   <= 8'h00;
      wr_data_reg  <= 8'h00;
      wr_full_reg  <= 1'b0;
      clear_ok_reg <= 1'b0;
    end
    else if (cs_sync_reg[1])
    begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      wr_full_reg  <= 1'b0;
      clear_ok_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          state_reg <= ST_CMD;
        ST_CMD:
          if (sclk_rise)
          begin
            shift_reg   <= cmd_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7)
            begin
              opcode_reg <= cmd_byte;
              case (cmd_byte)
                `OP_WRITE_SEGMENT: state_reg <= ST_WRITE;
                `OP_WRITE_CONFIG:  state_reg <= ST_WRITE;
                `OP_READ_SEGMENT:  state_reg <= ST_READ;
                `OP_READ_CONFIG:   state_reg <= ST_READ;
                `OP_READ_FLAGS:    state_reg <= ST_READ;
                `OP_CLEAR_FLAGS:
                begin
                  state_reg    <= ST_IGNORE;
                  clear_ok_reg <= 1'b1;
                end
                default:           state_reg <= ST_IGNORE;
              endcase
            end
          end
        ST_WRITE:
          if (sclk_rise)
          begin
            shift_reg   <= cmd_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            // only the first data byte is kept
            if (bit_cnt_reg == 3'h7 && !wr_full_reg)
            begin
              wr_data_reg <= cmd_byte;
              wr_full_reg <= 1'b1;
            end
          end
        ST_READ:
          state_reg <= ST_READ;
        ST_IGNORE:
          if (sclk_rise)
            clear_ok_reg <= 1'b0;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // commit strobes at the close of a frame
  always_comb
  begin
    seg_wr_pulse = 1'b0;
    cfg_wr_pulse = 1'b0;
    clr_pulse    = 1'b0;
    if (cs_rise)
    begin
      // settings apply once the write completes
      if (state_reg == ST_WRITE && wr_full_reg)
      begin
        seg_wr_pulse = (opcode_reg == `OP_WRITE_SEGMENT);
        cfg_wr_pulse = (opcode_reg == `OP_WRITE_CONFIG);
      end
      clr_pulse = (state_reg == ST_IGNORE) && clear_ok_reg;
    end
  end

  // read data, shifted out on falling clock edges
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx_reg          <= 8'h00;
      out_cnt_reg     <= 3'h0;
      spi_miso_out    <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end
    else if (cs_sync_reg[1])
    begin
      out_cnt_reg     <= 3'h0;
      spi_miso_oe_out <= 1'b0;
    end
    else if (state_reg == ST_READ && sclk_fall)
    begin
      spi_miso_oe_out <= 1'b1;
      out_cnt_reg     <= out_cnt_reg + 3'h1;
      // fresh register value on every byte
      if (out_cnt_reg == 3'h0)
      begin
        {spi_miso_out, tx_reg[7:1]} <=
          read_value(opcode_reg, segment_out, cfg_reg, flag_status_out);
        tx_reg[0] <= 1'b0;
      end
      else
      begin
        spi_miso_out <= tx_reg[7];
        tx_reg       <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // segment select register
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      segment_out    <= `SEG_RESET;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      strap_done_reg <= 1'b1;
      if (!strap_done_reg)
        segment_out <= nv_segment_low_in ? `SEG_LOWEST : `SEG_UPPERMOST;
      else if (seg_wr_pulse)
        segment_out <= wr_data_reg[2:0];
    end
  end

  // protocol and drive config register
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cfg_reg <= `CFG_RESET;
    else if (cfg_wr_pulse)
      cfg_reg <= wr_data_reg & `CFG_WRITE_MASK;
  end

  // decoded configuration outputs
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      protocol_out       <= PROTO_EXTENDED;
      hold_reset_en_out  <= 1'b1;
      vpp_accel_en_out   <= 1'b0;
      drive_strength_out <= 3'h7;
    end
    else
    begin
      if (!cfg_reg[`CFG_QUAD_BIT])
        protocol_out <= PROTO_QUAD;
      // dual when only bit 6 low
      else if (!cfg_reg[`CFG_DUAL_BIT])
        protocol_out <= PROTO_DUAL;
      else
        protocol_out <= PROTO_EXTENDED;
      hold_reset_en_out  <= cfg_reg[`CFG_HOLD_BIT];
      vpp_accel_en_out   <= ~cfg_reg[`CFG_VPP_BIT];
      drive_strength_out <= cfg_reg[2:0];
    end
  end

  // operation flags; an event beats a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      flag_status_out <= `FLG_RESET;
    else
    begin
      flag_status_out[`FLG_READY_BIT]      <= ~write_in_progress_in;
      flag_status_out[`FLG_ERASE_SUSP_BIT] <= erase_suspend_in;
      flag_status_out[`FLG_PROG_SUSP_BIT]  <= program_suspend_in;
      flag_status_out[`FLG_ADDR4_BIT]      <= four_byte_mode_in;
      flag_status_out[`FLG_ERASE_ERR_BIT]  <= erase_fail_in |
        (flag_status_out[`FLG_ERASE_ERR_BIT] & ~clr_pulse);
      flag_status_out[`FLG_PROG_ERR_BIT]   <= program_fail_in | zero_to_one_in |
        (flag_status_out[`FLG_PROG_ERR_BIT] & ~clr_pulse);
      flag_status_out[`FLG_VPP_ERR_BIT]    <= vpp_invalid_in |
        (flag_status_out[`FLG_VPP_ERR_BIT] & ~clr_pulse);
      flag_status_out[`FLG_PROTECT_BIT]    <= protect_hit_in |
        (flag_status_out[`FLG_PROTECT_BIT] & ~clr_pulse);
    end
  end

  // read stepping never touches the segment
  segment_address_map u_addr_map
  (
    .clk_sys_in     (clk_sys_in),
    .reset_n_in     (reset_n_in),
    .four_byte_in   (four_byte_mode_in),
    .segment_in     (segment_out),
    .addr_in        (core_addr_in),
    .load_in        (read_start_in | pe_start_in),
    .advance_in     (read_advance_in),
    .array_addr_out (array_addr_out)
  );

  sequence s_flags_opcode;
    state_reg == ST_CMD && sclk_rise && !cs_sync_reg[1] && bit_cnt_reg == 3'h7
      && cmd_byte == `OP_READ_FLAGS;
  endsequence

  sequence s_segment_commit;
    seg_wr_pulse && strap_done_reg ##1 1'b1;
  endsequence

  property p_flags_read;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    s_flags_opcode |=> state_reg == ST_READ;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flags read opcode not accepted");

  property p_segment_write;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    s_segment_commit |-> segment_out == $past(wr_data_reg[2:0], 1);
  endproperty
  a_segment_write: assert property (p_segment_write)
    else $error("segment write not applied");

  property p_ready_inverse;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    write_in_progress_in |=> !flag_status_out[`FLG_READY_BIT];
  endproperty
  a_ready_inverse: assert property (p_ready_inverse)
    else $error("ready flag not inverse of busy");

  property p_error_sticky;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    flag_status_out[`FLG_ERASE_ERR_BIT] && !clr_pulse |=>
      flag_status_out[`FLG_ERASE_ERR_BIT];
  endproperty
  a_error_sticky: assert property (p_error_sticky)
    else $error("erase error dropped without clear");

  property p_set_beats_clear;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    clr_pulse && program_fail_in |=> flag_status_out[`FLG_PROG_ERR_BIT];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("program error lost under clear");

  property p_addr_mode;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    ##1 flag_status_out[`FLG_ADDR4_BIT] == $past(four_byte_mode_in);
  endproperty
  a_addr_mode: assert property (p_addr_mode)
    else $error("address mode flag wrong");

  property p_quad_select;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    cfg_wr_pulse && !wr_data_reg[`CFG_QUAD_BIT] |-> ##2 protocol_out == PROTO_QUAD;
  endproperty
  a_quad_select: assert property (p_quad_select)
    else $error("quad protocol not selected");

  property p_pe_segment;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    pe_start_in && !four_byte_mode_in |=>
      array_addr_out[26:24] == $past(segment_out);
  endproperty
  a_pe_segment: assert property (p_pe_segment)
    else $error("program address outside segment");

  property p_die_wrap;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    read_advance_in && !read_start_in && !pe_start_in && !four_byte_mode_in
      && (&array_addr_out[24:0]) |=>
      array_addr_out == {$past(array_addr_out[26:25]), 25'h0000000};
  endproperty
  a_die_wrap: assert property (p_die_wrap)
    else $error("read left its die");

  property p_read_keeps_segment;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    read_advance_in && !seg_wr_pulse && strap_done_reg |=> $stable(segment_out);
  endproperty
  a_read_keeps_segment: assert property (p_read_keeps_segment)
    else $error("segment changed by read");

endmodule : flash_config_status_registers
`default_nettype wire

/* flash_config_status_registers_tb_top.sv */
// self-checking bench of the configuration and status register block
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module flash_config_status_registers_tb_top;
  import flash_regs_pkg::*;
  logic clk_sys_in, reset_n_in, spi_sclk_in, spi_cs_n_in, spi_mosi_in;
  logic spi_miso_out, spi_miso_oe_out, nv_segment_low_in;
  logic write_in_progress_in, erase_suspend_in, program_suspend_in, four_byte_mode_in;
  logic erase_fail_in, program_fail_in, zero_to_one_in, vpp_invalid_in, protect_hit_in;
  logic [31:0] core_addr_in, r;
  logic read_start_in, read_advance_in, pe_start_in, hold_reset_en_out, vpp_accel_en_out;
  logic [26:0] array_addr_out;
  protocol_e   protocol_out, p;
  logic [2:0]  drive_strength_out, segment_out;
  logic [7:0]  flag_status_out, d, err, ef, exp_byte;
  logic [7:0]  expq[$];
  int          num_errors, n_tests, cycles, seed;

  flash_config_status_registers dut (.clk_sys_in, .reset_n_in, .spi_sclk_in, .spi_cs_n_in,
    .spi_mosi_in, .spi_miso_out, .spi_miso_oe_out, .nv_segment_low_in, .write_in_progress_in,
    .erase_suspend_in, .program_suspend_in, .four_byte_mode_in, .erase_fail_in,
    .program_fail_in, .zero_to_one_in, .vpp_invalid_in, .protect_hit_in, .core_addr_in,
    .read_start_in, .read_advance_in, .pe_start_in, .array_addr_out, .protocol_out,
    .hold_reset_en_out, .vpp_accel_en_out, .drive_strength_out, .segment_out,
    .flag_status_out);

  serial_host_model host (.sclk_out(spi_sclk_in), .cs_n_out(spi_cs_n_in),
    .mosi_out(spi_mosi_in), .miso_in(spi_miso_out), .miso_oe_in(spi_miso_oe_out));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic end_sim;
    $display("counts: %0d compared, %0d wrong", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // each read byte is matched against the oldest note
  initial
  forever
  begin
    @(host.got);
    // take the note once, so a mismatch report cannot pop a second one
    exp_byte = expq.pop_front();
    `CHK(host.rd_byte, exp_byte)
  end

  task automatic rd(input logic [7:0] op, input logic [7:0] e, input int n);
    repeat (n) expq.push_back(e);
    host.xfer(op, 0, 8'h00, n);
  endtask : rd

  task automatic wr(input logic [7:0] op, input logic [7:0] v, input int n);
    host.xfer(op, n, v, 0);
    repeat (4) @(negedge clk_sys_in);
  endtask : wr

  task automatic load(input logic [31:0] a, input logic rs, input logic adv);
    @(negedge clk_sys_in);
    core_addr_in = a;
    read_start_in = rs;
    pe_start_in = ~rs;
    @(negedge clk_sys_in);
    {read_start_in, pe_start_in, read_advance_in} = {2'b00, adv};
    @(negedge clk_sys_in);
    read_advance_in = 1'b0;
    @(negedge clk_sys_in);
  endtask : load

  initial
  begin
    {reset_n_in, nv_segment_low_in, core_addr_in, read_start_in, read_advance_in} = '0;
    {pe_start_in, write_in_progress_in, erase_suspend_in, program_suspend_in} = '0;
    {four_byte_mode_in, erase_fail_in, program_fail_in, zero_to_one_in} = '0;
    {vpp_invalid_in, protect_hit_in, num_errors, n_tests, cycles, err} = '0;
    seed = 32'h816a;
    repeat (3) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    `CHK(segment_out, `SEG_UPPERMOST)
    `CHK(flag_status_out, `FLG_RESET)
    `CHK({protocol_out, hold_reset_en_out, vpp_accel_en_out}, {PROTO_EXTENDED, 2'b10})
    rd(`OP_READ_SEGMENT, 8'h07, 1);
    rd(`OP_READ_CONFIG, `CFG_RESET, 1);
    $display("test reset values done");
    for (int s = 0; s < 8; s++)
    begin
      r = $random(seed);
      wr(`OP_WRITE_SEGMENT, {r[7:3], s[2:0]}, 1);
      rd(`OP_READ_SEGMENT, {5'h00, s[2:0]}, 1);
      `CHK(segment_out, s[2:0])
      load(r, r[9], 1'b0);
      `CHK(array_addr_out, {s[2:0], r[23:0]})
      four_byte_mode_in = 1'b1;
      load(r, r[10], 1'b0);
      `CHK(array_addr_out, r[26:0])
      four_byte_mode_in = 1'b0;
    end
    load(32'h00ffffff, 1'b1, 1'b1);
    `CHK(array_addr_out, 27'h6000000)
    wr(`OP_WRITE_SEGMENT, 8'h02, 1);
    load(32'h00ffffff, 1'b1, 1'b1);
    `CHK(array_addr_out, 27'h3000000)
    `CHK(segment_out, 3'h2)
    $display("test segment addressing done");
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      d[7:6] = i[1:0];
      p = !d[7] ? PROTO_QUAD : (!d[6] ? PROTO_DUAL : PROTO_EXTENDED);
      wr(`OP_WRITE_CONFIG, d, 1);
      `CHK({protocol_out, hold_reset_en_out}, {p, d[4]})
      `CHK({vpp_accel_en_out, drive_strength_out}, {~d[3], d[2:0]})
      rd(`OP_READ_CONFIG, d & `CFG_WRITE_MASK, 1);
    end
    $display("test config done");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      @(negedge clk_sys_in);
      {write_in_progress_in, erase_suspend_in, program_suspend_in, four_byte_mode_in} = r[3:0];
      {erase_fail_in, program_fail_in, zero_to_one_in, vpp_invalid_in, protect_hit_in} = r[8:4];
      @(negedge clk_sys_in);
      {erase_fail_in, program_fail_in, zero_to_one_in, vpp_invalid_in, protect_hit_in} = '0;
      err = err | {2'b00, r[8], r[7] | r[6], r[5], 1'b0, r[4], 1'b0};
      @(negedge clk_sys_in);
      ef = err | {~r[3], r[2], 3'b000, r[1], 1'b0, r[0]};
      `CHK(flag_status_out, ef)
      rd(`OP_READ_FLAGS, ef, 2);
      wr(`OP_CLEAR_FLAGS, 8'h00, i % 2);
      if (i % 2 == 0)
        err = 8'h00;
      `CHK(flag_status_out, err | (ef & 8'hc5))
    end
    // an error event that is still high during the clear must win
    @(negedge clk_sys_in);
    program_fail_in = 1'b1;
    wr(`OP_CLEAR_FLAGS, 8'h00, 0);
    program_fail_in = 1'b0;
    @(negedge clk_sys_in);
    `CHK(flag_status_out[`FLG_PROG_ERR_BIT], 1'b1)
    wr(`OP_CLEAR_FLAGS, 8'h00, 0);
    `CHK(flag_status_out & 8'h3a, 8'h00)
    `CHK(expq.size(), 0)
    $display("test flags done");
    end_sim();
  end
endmodule : flash_config_status_registers_tb_top

`default_nettype wire

/* flash_regs_params.svh */
// register layout, command codes and reset values of the configuration block
`ifndef FLASH_REGS_PARAMS_SVH
`define FLASH_REGS_PARAMS_SVH

// command codes
`define OP_WRITE_SEGMENT     8'hc5
`define OP_READ_SEGMENT      8'hc8
`define OP_READ_FLAGS        8'h70
`define OP_CLEAR_FLAGS       8'h50
`define OP_WRITE_CONFIG      8'h61
`define OP_READ_CONFIG       8'h65

// segment select register
`define SEG_RESET            3'h0
`define SEG_LOWEST           3'h0
`define SEG_UPPERMOST        3'h7

// protocol and drive config register
`define CFG_RESET            8'hdf
`define CFG_WRITE_MASK       8'hdf
`define CFG_QUAD_BIT         7
`define CFG_DUAL_BIT         6
`define CFG_HOLD_BIT         4
`define CFG_VPP_BIT          3

// operation flags register
`define FLG_READY_BIT        7
`define FLG_ERASE_SUSP_BIT   6
`define FLG_ERASE_ERR_BIT    5
`define FLG_PROG_ERR_BIT     4
`define FLG_VPP_ERR_BIT      3
`define FLG_PROG_SUSP_BIT    2
`define FLG_PROTECT_BIT      1
`define FLG_ADDR4_BIT        0
`define FLG_RESET            8'h80

// array geometry: 1 Gb array, 256 Mb dies
`define ARRAY_ADDR_W         27
`define DIE_OFFSET_W         25

`endif

/* flash_regs_pkg.sv */
// types shared by the configuration and status register block
`default_nettype none
package flash_regs_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_CMD    = 5'b00010,
    ST_WRITE  = 5'b00100,
    ST_READ   = 5'b01000,
    ST_IGNORE = 5'b10000
  } link_state_e;

  typedef enum logic [1:0] {
    PROTO_EXTENDED = 2'b00,
    PROTO_DUAL     = 2'b01,
    PROTO_QUAD     = 2'b10
  } protocol_e;

endpackage : flash_regs_pkg
`default_nettype wire

/* segment_address_map.sv */
// array address former: segment extension and die-bounded read stepping in 3-byte mode
`timescale 1ns/10ps
`default_nettype none
`include "flash_regs_params.svh"

module segment_address_map
(
  // system
  input  wire logic                       clk_sys_in,
  input  wire logic                       reset_n_in,
  // address source
  input  wire logic                       four_byte_in,
  input  wire logic [2:0]                 segment_in,
  input  wire logic [31:0]                addr_in,
  input  wire logic                       load_in,
  input  wire logic                       advance_in,
  // array address
  output logic      [`ARRAY_ADDR_W-1:0]   array_addr_out
);

  // next read address; 3-byte reads wrap inside their own die
  function automatic logic [`ARRAY_ADDR_W-1:0] step_addr(
    input logic [`ARRAY_ADDR_W-1:0] a,
    input logic                     four_byte
  );
    logic [`DIE_OFFSET_W-1:0] off;
    off = a[`DIE_OFFSET_W-1:0] + {{(`DIE_OFFSET_W-1){1'b0}}, 1'b1};
    if (four_byte)
      step_addr = a + {{(`ARRAY_ADDR_W-1){1'b0}}, 1'b1};
    else
      step_addr = {a[`ARRAY_ADDR_W-1:`DIE_OFFSET_W], off};
  endfunction : step_addr

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      array_addr_out <= '0;
    else if (load_in)
    begin
      if (four_byte_in)
        array_addr_out <= addr_in[`ARRAY_ADDR_W-1:0];
      else
        array_addr_out <= {segment_in, addr_in[23:0]};
    end
    else if (advance_in)
      array_addr_out <= step_addr(array_addr_out, four_byte_in);
  end

endmodule : segment_address_map
`default_nettype wire

/* serial_host_model.sv */
// serial host model issuing register commands on the link
`timescale 1ns/10ps
`default_nettype none

module serial_host_model
(
  // link to device
  output logic       sclk_out,
  output logic       cs_n_out,
  output logic       mosi_out,
  input  wire logic  miso_in,
  input  wire logic  miso_oe_in
);
  logic [7:0] rd_byte;
  event       got;

  // clock idles low between frames
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      mosi_out = b[i];
      #400 sclk_out = 1'b1;
      #400 sclk_out = 1'b0;
    end
  endtask : send

  // frame: opcode, nw copies of wd, then nr bytes read back
  task automatic xfer(input logic [7:0] op, input int nw, input logic [7:0] wd, input int nr);
    cs_n_out = 1'b0;
    #300;
    send(op);
    repeat (nw) send(wd);
    repeat (nr)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        #400 sclk_out = 1'b1;
        // undriven line never counts as data
        rd_byte[i] = miso_oe_in ? miso_in : 1'bx;
        #400 sclk_out = 1'b0;
      end
      -> got;
    end
    #400 cs_n_out = 1'b1;
    // released data line must not hold its last value
    mosi_out = ~mosi_out;
    #400;
  endtask : xfer
endmodule : serial_host_model

`default_nettype wire
